// File: core/qsi_pkg.sv
// Constants and types of the quick software start-up sequencer.
// Assumes a 50 MHz APB clock and a module with eight data path lanes.
package qsi_pkg;

  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned LANES = 8;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DEINIT = 8'h04;
  localparam logic [7:0] ADDR_TXDIS = 8'h08;
  localparam logic [7:0] ADDR_SQUELCH = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'h18;
  localparam logic [7:0] ADDR_ACTIVE = 8'h1c;
  localparam logic [7:0] ADDR_STAGED0 = 8'h20;

  // Control register field positions
  localparam int unsigned CTRL_SW_REQ_BIT = 0;
  localparam int unsigned CTRL_ALLOW_HW_BIT = 1;
  // Flag and mask layout: module flag in bit 0, lane flags in 15:8
  localparam int unsigned FLAG_MODULE_BIT = 0;
  localparam int unsigned FLAG_LANE_LSB = 8;
  // Status layout: module state in 3:0, lane state codes from bit 8
  localparam int unsigned STAT_LANE_LSB = 8;

  // Values after reset
  localparam logic RST_SW_REQ = 1'b0;
  localparam logic RST_ALLOW_HW = 1'b1;
  localparam logic [7:0] RST_DEINIT = 8'h00;
  localparam logic [7:0] RST_TXDIS = 8'h00;
  localparam logic [7:0] RST_SQUELCH = 8'h00;
  localparam logic [31:0] RST_MASK = 32'h0000ff01;
  localparam logic [31:0] DEFAULT_PATH_CFG = 32'h00000001;

  // Timing: power-up and per-lane path initialisation
  localparam int unsigned PWRUP_TIME_NS = 2000;
  localparam int unsigned PATH_INIT_TIME_NS = 1000;
  localparam int unsigned PWRUP_CYCLES = (PWRUP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PATH_INIT_CYCLES = (PATH_INIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] PWRUP_LAST = 8'(PWRUP_CYCLES - 1);
  localparam logic [7:0] PATH_INIT_LAST = 8'(PATH_INIT_CYCLES - 1);

  typedef enum logic [3:0] {
    MOD_MGMT_INIT = 4'h1,
    MOD_LOW_POWER = 4'h2,
    MOD_POWERING_UP = 4'h4,
    MOD_READY = 4'h8
  } qsi_mod_state_t;

  typedef enum logic [4:0] {
    PATH_DEACTIVATED = 5'h01,
    PATH_INIT = 5'h02,
    PATH_INITIALIZED = 5'h04,
    PATH_TX_TURN_ON = 5'h08,
    PATH_ACTIVATED = 5'h10
  } qsi_path_state_t;

  // Host-writable controls
  typedef struct packed {
    logic sw_low_power_request;
    logic allow_hw_low_power_request;
    logic [7:0] datapath_deinit_mask;
    logic [7:0] tx_output_disable;
    logic [7:0] tx_forced_squelch;
  } qsi_ctrl_t;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } qsi_apb_req_t;

endpackage : qsi_pkg

// File: core/qsi_sequencer.sv
// Module-side start-up sequencer: management init, low power park,
// software-released power-up and automatic data path activation.
// Assumes an APB master on pclk and a host-driven low power request pin.
//
// Functional notes
// RL1 - Management init loads control power-on defaults
// RL2 - Copy default path config into active, staged0
// RL3 - Entering low power sets module flag
// RL4 - Stay low power while request allowed
// RL5 - Host reads flags; interrupt then drops
// RL6 - Host enables transmitters before releasing low power
// RL7 - Host clears allow bit, pin stays asserted
// RL8 - Low power signal false starts power-up
// RL9 - Entering ready sets module flag again
// RL10 - Ready and no deinit: paths initialise
// RL11 - Initialized and not deactivated: turn on
// RL12 - Enable transmit outputs before path activated
// RL13 - Entering activated sets lane flag bits
// RL14 - Host waits second interrupt, then traffic
// RL15 - Host asserts request pin, select, releases reset
// RL16 - Host asserts request pin for software start
// RL17 - Deinit mask FFh blocks automatic path init
// RL18 - Interrupt held until all set flags read
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module qsi_sequencer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire qsi_pkg::qsi_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host pins
  input wire logic hw_low_power_request,
  output logic interrupt_n,
  // Transmit outputs per lane
  output logic [qsi_pkg::LANES-1:0] tx_output_enable
);
  import qsi_pkg::*;

  qsi_ctrl_t ctrl_r;
  qsi_mod_state_t mod_state_r;
  qsi_path_state_t path_state_r [LANES];
  logic [7:0] pwrup_cnt_r;
  logic [7:0] init_cnt_r [LANES];
  logic [31:0] active_cfg_r;
  logic [31:0] staged0_cfg_r;
  logic [31:0] flags_r;
  logic [31:0] mask_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_n_r;
  logic [LANES-1:0] tx_en_r;
  logic low_power_transition_signal;
  logic [LANES-1:0] deinit_transition_signal;
  logic [LANES-1:0] deactivate_transition_signal;
  logic [31:0] flag_set;
  logic [31:0] rd_word;
  logic wr_done;
  logic rd_done;
  logic mapped;

  // Decoding for the error answer; the read mux decodes with its own case
  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      ADDR_CTRL, ADDR_DEINIT, ADDR_TXDIS, ADDR_SQUELCH, ADDR_STATUS,
      ADDR_FLAGS, ADDR_MASK, ADDR_ACTIVE, ADDR_STAGED0: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction : addr_mapped

  // Transfer completes at the edge that samples pready high
  assign wr_done = apb_req.psel & apb_req.penable & pready_r & apb_req.pwrite;
  assign rd_done = apb_req.psel & apb_req.penable & pready_r & ~apb_req.pwrite;
  assign mapped = addr_mapped(apb_req.paddr);

  // Transition signals: the allow bit gates the pin
  assign low_power_transition_signal = ctrl_r.sw_low_power_request |
    (ctrl_r.allow_hw_low_power_request & hw_low_power_request); // see RL4 see RL8 see RL16
  assign deinit_transition_signal = {LANES{low_power_transition_signal | (mod_state_r != MOD_READY)}} |
    ctrl_r.datapath_deinit_mask; // see RL17
  assign deactivate_transition_signal = deinit_transition_signal | ctrl_r.tx_output_disable;

  // Read data mux
  always_comb begin
    rd_word = 32'h00000000;
    case (apb_req.paddr)
      ADDR_CTRL: begin
        rd_word[CTRL_SW_REQ_BIT] = ctrl_r.sw_low_power_request;
        rd_word[CTRL_ALLOW_HW_BIT] = ctrl_r.allow_hw_low_power_request;
      end
      ADDR_DEINIT: rd_word[7:0] = ctrl_r.datapath_deinit_mask;
      ADDR_TXDIS: rd_word[7:0] = ctrl_r.tx_output_disable;
      ADDR_SQUELCH: rd_word[7:0] = ctrl_r.tx_forced_squelch;
      ADDR_STATUS: begin
        rd_word[3:0] = mod_state_r;
        for (int i = 0; i < 4; i++) begin
          // Four lanes fit beside the module state; lanes 4-7 are not reported
          rd_word[STAT_LANE_LSB + 5*i +: 5] = path_state_r[i];
        end
      end
      ADDR_FLAGS: rd_word = flags_r;
      ADDR_MASK: rd_word = mask_r;
      ADDR_ACTIVE: rd_word = active_cfg_r;
      ADDR_STAGED0: rd_word = staged0_cfg_r;
      default: rd_word = 32'h00000000;
    endcase
  end

  // APB answer: one wait state, pready registered so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= apb_req.psel & apb_req.penable & ~pready_r;
      pslverr_r <= apb_req.psel & apb_req.penable & ~pready_r & ~mapped;
      if (apb_req.psel & apb_req.penable & ~pready_r) begin
        prdata_r <= rd_word;
      end
    end
  end

  // Host control registers with power-on defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r.sw_low_power_request <= RST_SW_REQ; // see RL1
      ctrl_r.allow_hw_low_power_request <= RST_ALLOW_HW; // see RL1
      ctrl_r.datapath_deinit_mask <= RST_DEINIT; // see RL1
      ctrl_r.tx_output_disable <= RST_TXDIS; // see RL1
      ctrl_r.tx_forced_squelch <= RST_SQUELCH; // see RL1
      mask_r <= RST_MASK;
    end else if (wr_done) begin
      case (apb_req.paddr)
        ADDR_CTRL: begin
          ctrl_r.sw_low_power_request <= apb_req.pwdata[CTRL_SW_REQ_BIT];
          ctrl_r.allow_hw_low_power_request <= apb_req.pwdata[CTRL_ALLOW_HW_BIT];
        end
        ADDR_DEINIT: ctrl_r.datapath_deinit_mask <= apb_req.pwdata[7:0];
        ADDR_TXDIS: ctrl_r.tx_output_disable <= apb_req.pwdata[7:0];
        ADDR_SQUELCH: ctrl_r.tx_forced_squelch <= apb_req.pwdata[7:0];
        ADDR_MASK: mask_r <= apb_req.pwdata;
        default: ;
      endcase
    end
  end

  // Control sets: defaults copied during management init, staged set writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_cfg_r <= 32'h00000000;
      staged0_cfg_r <= 32'h00000000;
    end else if (mod_state_r == MOD_MGMT_INIT) begin
      active_cfg_r <= DEFAULT_PATH_CFG; // see RL2
      staged0_cfg_r <= DEFAULT_PATH_CFG; // see RL2
    end else if (wr_done && apb_req.paddr == ADDR_STAGED0) begin
      staged0_cfg_r <= apb_req.pwdata;
    end
  end

  // Module state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_state_r <= MOD_MGMT_INIT;
      pwrup_cnt_r <= 8'h00;
    end else begin
      case (mod_state_r)
        MOD_MGMT_INIT: mod_state_r <= MOD_LOW_POWER; // see RL1
        MOD_LOW_POWER: begin
          pwrup_cnt_r <= 8'h00;
          if (!low_power_transition_signal) begin
            mod_state_r <= MOD_POWERING_UP; // see RL8
          end
        end
        MOD_POWERING_UP: begin
          // A late low power request aborts the power-up
          if (low_power_transition_signal) begin
            mod_state_r <= MOD_LOW_POWER;
          end else if (pwrup_cnt_r == PWRUP_LAST) begin
            mod_state_r <= MOD_READY;
          end else begin
            pwrup_cnt_r <= pwrup_cnt_r + 8'h01;
          end
        end
        MOD_READY: begin
          if (low_power_transition_signal) begin
            mod_state_r <= MOD_LOW_POWER;
          end
        end
        default: mod_state_r <= MOD_MGMT_INIT;
      endcase
    end
  end

  // Data path state machines, one per lane
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < LANES; i++) begin
        path_state_r[i] <= PATH_DEACTIVATED; // see RL2
        init_cnt_r[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < LANES; i++) begin
        case (path_state_r[i])
          PATH_DEACTIVATED: begin
            init_cnt_r[i] <= 8'h00;
            if (!deinit_transition_signal[i]) begin
              path_state_r[i] <= PATH_INIT; // see RL10
            end
          end
          PATH_INIT: begin
            if (deinit_transition_signal[i]) begin
              path_state_r[i] <= PATH_DEACTIVATED;
            end else if (init_cnt_r[i] == PATH_INIT_LAST) begin
              path_state_r[i] <= PATH_INITIALIZED;
            end else begin
              init_cnt_r[i] <= init_cnt_r[i] + 8'h01;
            end
          end
          PATH_INITIALIZED: begin
            if (deinit_transition_signal[i]) begin
              path_state_r[i] <= PATH_DEACTIVATED;
            end else if (!deactivate_transition_signal[i]) begin
              path_state_r[i] <= PATH_TX_TURN_ON; // see RL11
            end
          end
          PATH_TX_TURN_ON: begin
            // Activated only once the transmitter enable has been driven
            if (deactivate_transition_signal[i]) begin
              path_state_r[i] <= PATH_INITIALIZED;
            end else if (tx_en_r[i]) begin
              path_state_r[i] <= PATH_ACTIVATED; // see RL12
            end
          end
          PATH_ACTIVATED: begin
            if (deinit_transition_signal[i]) begin
              path_state_r[i] <= PATH_DEACTIVATED;
            end else if (deactivate_transition_signal[i]) begin
              path_state_r[i] <= PATH_INITIALIZED;
            end
          end
          default: path_state_r[i] <= PATH_DEACTIVATED;
        endcase
      end
    end
  end

  // Transmit enables; forced squelch mutes without changing the path state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_en_r <= '0;
    end else begin
      for (int i = 0; i < LANES; i++) begin
        tx_en_r[i] <= (path_state_r[i] == PATH_TX_TURN_ON || path_state_r[i] == PATH_ACTIVATED) &&
          !deactivate_transition_signal[i] && !ctrl_r.tx_forced_squelch[i]; // see RL12
      end
    end
  end

  // Flag set events: entry into low power, ready, and lane activated
  always_comb begin
    flag_set = 32'h00000000;
    flag_set[FLAG_MODULE_BIT] =
      (mod_state_r != MOD_LOW_POWER && mod_state_r != MOD_READY &&
       ((mod_state_r == MOD_MGMT_INIT) ||
        (mod_state_r == MOD_POWERING_UP && low_power_transition_signal))) || // see RL3
      (mod_state_r == MOD_READY && low_power_transition_signal) || // see RL3
      (mod_state_r == MOD_POWERING_UP && !low_power_transition_signal && pwrup_cnt_r == PWRUP_LAST); // see RL9
    for (int i = 0; i < LANES; i++) begin
      flag_set[FLAG_LANE_LSB + i] = path_state_r[i] == PATH_TX_TURN_ON && tx_en_r[i] &&
        !deactivate_transition_signal[i]; // see RL13
    end
  end

  // Sticky flags: cleared by reading them or writing ones; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= 32'h00000000;
    end else begin
      if (rd_done && apb_req.paddr == ADDR_FLAGS) begin
        // Only bits returned to the host clear; an event after capture survives
        flags_r <= (flags_r & ~prdata_r) | flag_set; // see RL5
      end else if (wr_done && apb_req.paddr == ADDR_FLAGS) begin
        flags_r <= (flags_r & ~apb_req.pwdata) | flag_set;
      end else begin
        flags_r <= flags_r | flag_set;
      end
    end
  end

  // Interrupt held while any unmasked flag stays set; kept active low in the flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= ~|(flags_r & mask_r); // see RL18 see RL5
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign interrupt_n = irq_n_r;
  assign tx_output_enable = tx_en_r;

endmodule : qsi_sequencer

// File: tb/qsi_host_model.sv
// Host side of the pin interface: drives the low power request pin.
// Assumes pclk and presetn from the bench; the pin is synchronous.
`timescale 1ns/10ps
module qsi_host_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic park,
  // Pin toward the module
  output logic hw_low_power_request
);
  logic host_tx_on_r;

  // Pin is high from power-up so the module parks; it is never let go
  // before the host transmitters send a valid signal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_tx_on_r <= 1'b0;
      hw_low_power_request <= 1'b1;
    end else begin
      host_tx_on_r <= 1'b1;
      hw_low_power_request <= park || !host_tx_on_r;
    end
  end
endmodule : qsi_host_model

// File: tb/qsi_sequencer_asserts.sv
// Port checks of the start-up sequencer.
// Assumes default mask and no forced squelch during checked sequences.
`timescale 1ns/10ps
module qsi_sequencer_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire qsi_pkg::qsi_apb_req_t apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic hw_low_power_request,
  input wire logic interrupt_n,
  input wire logic [qsi_pkg::LANES-1:0] tx_output_enable
);
  import qsi_pkg::*;
  logic [1:0] flag_acc_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Flag or mask access history; the flop stage may delay the release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_acc_r <= 2'b00;
    end else begin
      flag_acc_r <= {flag_acc_r[0], pready && (apb_req.paddr == ADDR_FLAGS || apb_req.paddr == ADDR_MASK)};
    end
  end
  // Allow bit cleared while pin high and interrupt idle
  sequence s_release;
    pready && apb_req.pwrite && apb_req.paddr == ADDR_CTRL && apb_req.pwdata[1:0] == 2'b00
      && hw_low_power_request && interrupt_n;
  endsequence
  // Quiet power-up, then the ready flag drops the interrupt
  sequence s_power_up;
    interrupt_n [*8] ##[90:96] !interrupt_n;
  endsequence
  a_one_wait_state: assert property (apb_req.psel && apb_req.penable && !pready |=> pready)
    else $error("pready not after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than a cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (pready && (apb_req.paddr > 8'h20 || apb_req.paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access not refused");
  a_low_power_flag: assert property ($rose(presetn) |-> ##[1:3] !interrupt_n)
    else $error("no interrupt on low power entry");
  a_power_up_time: assert property (s_release |=> s_power_up)
    else $error("ready flag timing wrong");
  a_tx_then_flag: assert property ($rose(|tx_output_enable) |-> ##[1:3] !interrupt_n)
    else $error("no lane flag after tx enable");
  a_irq_held: assert property ($rose(interrupt_n) |-> |flag_acc_r)
    else $error("interrupt released without flag access");
endmodule : qsi_sequencer_asserts

bind qsi_sequencer qsi_sequencer_asserts qsi_sequencer_asserts_inst (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .hw_low_power_request(hw_low_power_request), .interrupt_n(interrupt_n), .tx_output_enable(tx_output_enable));

// File: tb/test_qsi_sequencer.sv
// Bench of the start-up sequencer: APB tasks and the software start flow.
// Assumes the host model holds the request pin high until park is cleared.
`timescale 1ns/10ps
module test_qsi_sequencer;
  import qsi_pkg::*;
  logic pclk;
  logic presetn;
  logic park;
  qsi_apb_req_t apb_req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hw_low_power_request;
  logic interrupt_n;
  logic [LANES-1:0] tx_output_enable;
  int errors;
  int samples_checked;
  int n;
  logic [31:0] rdat;
  logic rerr;
  logic [7:0] ra [7] = '{ADDR_CTRL, ADDR_DEINIT, ADDR_TXDIS, ADDR_SQUELCH, ADDR_MASK, ADDR_ACTIVE, ADDR_STAGED0};
  logic [31:0] rv [7] = '{32'h2, 32'h0, 32'h0, 32'h0, 32'hff01, 32'h1, 32'h1};

  qsi_sequencer qsi_sequencer_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hw_low_power_request(hw_low_power_request),
    .interrupt_n(interrupt_n), .tx_output_enable(tx_output_enable));
  qsi_host_model qsi_host_model_inst (.pclk(pclk), .presetn(presetn), .park(park),
    .hw_low_power_request(hw_low_power_request));

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // One transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rdat = prdata;
    rerr = pslverr;
    if (n == 16) begin
      errors++;
      tally_and_finish();
    end
    apb_req <= '0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd

  // Bounded wait for an interrupt level; a hang ends the run
  task automatic wait_irq(input logic lvl);
    for (n = 0; n < 400; n++) begin
      @(posedge pclk);
      if (interrupt_n === lvl) break;
    end
    if (n == 400) begin
      errors++;
      tally_and_finish();
    end
  endtask : wait_irq

  // Status word: module code, same path code on lanes 0-3
  function automatic logic [31:0] st(input logic [3:0] m, input logic [4:0] c);
    st = {4'h0, c, c, c, c, 4'h0, m};
  endfunction : st

  initial begin
    presetn = 1'b0;
    park = 1'b1;
    apb_req = '0;
    errors = 0;
    samples_checked = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wait_irq(1'b0);
    rd(ADDR_STATUS, st(4'h2, 5'h01));
    for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
    // Mask hides the flag, unmask shows it, write-one clears it
    apb(1'b1, ADDR_MASK, 32'h0);
    repeat (3) @(posedge pclk);
    chk({31'h0, interrupt_n}, 32'h1);
    apb(1'b1, ADDR_MASK, 32'hff01);
    wait_irq(1'b0);
    apb(1'b1, ADDR_FLAGS, 32'h1);
    wait_irq(1'b1);
    rd(ADDR_FLAGS, 32'h0);
    // Unmapped place refused, read-only place kept
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    apb(1'b1, ADDR_STAGED0, 32'h5a);
    rd(ADDR_STAGED0, 32'h5a);
    apb(1'b1, ADDR_ACTIVE, 32'h5a);
    rd(ADDR_ACTIVE, 32'h1);
    // Parked until the allow bit is cleared
    repeat (20) @(posedge pclk);
    rd(ADDR_STATUS, st(4'h2, 5'h01));
    chk({24'h0, tx_output_enable}, 32'h0);
    apb(1'b1, ADDR_DEINIT, 32'hff);
    apb(1'b1, ADDR_CTRL, 32'h0);
    wait_irq(1'b0);
    rd(ADDR_STATUS, st(4'h8, 5'h01));
    rd(ADDR_FLAGS, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, interrupt_n}, 32'h1);
    repeat (80) @(posedge pclk);
    rd(ADDR_STATUS, st(4'h8, 5'h01));
    chk({24'h0, tx_output_enable}, 32'h0);
    // Releasing the mask lets all paths come up
    apb(1'b1, ADDR_DEINIT, 32'h0);
    rd(ADDR_STATUS, st(4'h8, 5'h02));
    for (n = 0; n < 200; n++) begin
      @(posedge pclk);
      if (tx_output_enable === 8'hff) break;
    end
    if (n == 200) begin
      errors++;
      tally_and_finish();
    end
    chk({31'h0, n inside {[40:55]}}, 32'h1);
    chk({24'h0, tx_output_enable}, 32'hff);
    wait_irq(1'b0);
    rd(ADDR_FLAGS, 32'hff00);
    rd(ADDR_STATUS, st(4'h8, 5'h10));
    wait_irq(1'b1);
    // Second reset in mid-run restores defaults
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    wait_irq(1'b0);
    rd(ADDR_CTRL, 32'h2);
    chk({24'h0, tx_output_enable}, 32'h0);
    rd(ADDR_FLAGS, 32'h1);
    wait_irq(1'b1);
    // Pin dropped with the allow bit still set: the module powers up alone
    park <= 1'b0;
    wait_irq(1'b0);
    rd(ADDR_STATUS, st(4'h8, 5'h02));
    rd(ADDR_FLAGS, 32'h1);
    // Software request sends the module back to low power, paths torn down
    apb(1'b1, ADDR_CTRL, 32'h1);
    rd(ADDR_STATUS, st(4'h2, 5'h01));
    rd(ADDR_FLAGS, 32'h1);
    tally_and_finish();
  end
endmodule : test_qsi_sequencer
